// *** tb/variable_length_op_decoder_bench.sv ***
// self-checking bench for the variable-length operation decoder
`timescale 1ns/1ps

module variable_length_op_decoder_bench;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        fill_valid = 1'b0;
  logic [7:0]  fill_byte = 8'h00;
  logic        fill_ready;
  logic        line_valid;
  logic        sched_ready;
  logic [63:0] line_ops;
  logic [3:0]  line_slot_vld;
  logic [1:0]  mode = 2'h0;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          rom_seen = 0;
  int          rom_exp = 0;
  int          pair_cnt = 0;
  int          cycles = 0;
  logic [15:0] exp_q[$];
  int          rom_len[4] = '{4, 7, 12, 20};

  always #2.5 ref_clk = ~ref_clk;

  vld_decoder uut (
    .ref_clk       (ref_clk),
    .sys_rst       (sys_rst),
    .fill_valid    (fill_valid),
    .fill_byte     (fill_byte),
    .fill_ready    (fill_ready),
    .line_valid    (line_valid),
    .sched_ready   (sched_ready),
    .line_ops      (line_ops),
    .line_slot_vld (line_slot_vld)
  );

  vld_sched_model sched (
    .ref_clk       (ref_clk),
    .sys_rst       (sys_rst),
    .mode          (mode),
    .line_valid    (line_valid),
    .line_slot_vld (line_slot_vld),
    .sched_ready   (sched_ready)
  );

  task automatic bad(input string msg);
    error_cnt++;
    $display("BAD t=%0t %s", $time, msg);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad("run timed out");
      summarize();
    end
  end

  // ---------------------------------------------------------------
  // line monitor: lines stand until taken, so judge them mid-cycle
  // ---------------------------------------------------------------
  always @(negedge ref_clk) begin
    logic [15:0] op;
    if (sys_rst === 1'b0 && line_valid === 1'b1 && sched_ready === 1'b1) begin
      tests_run++;
      if ((line_slot_vld inside {4'h1, 4'h3, 4'h7, 4'hF}) !== 1'b1)
        bad("slot valid mask not contiguous");
      if (line_ops[15:8] === 8'h40 && line_slot_vld !== 4'hF)
        bad("first vector line not four ops");
      if (line_ops[15] === 1'b1)
        rom_seen++;
      for (int i = 0; i < 4; i++) begin
        op = line_ops[16*i +: 16];
        if (line_slot_vld[i] === 1'b1) begin
          if (i > 0 && op[14:8] === 7'h00)
            pair_cnt++;
          if (exp_q.size() == 0)
            bad("unexpected op");
          else if (op !== exp_q.pop_front())
            bad("op mismatch");
        end
      end
    end
  end

  // byte held until a cycle with room; taken at the following edge
  task automatic send(input logic [7:0] b);
    logic ok;
    ok = 1'b0;
    fill_valid <= 1'b1;
    fill_byte <= b;
    while (ok !== 1'b1) begin
      @(negedge ref_clk);
      ok = fill_ready;
      @(posedge ref_clk);
    end
  endtask

  task automatic ins(input logic [7:0] b);
    int l;
    int n;
    logic [1:0] c;
    l = (b[3:0] == 4'h0) ? 1 : int'(b[3:0]);
    if (b[7] || l > 11)
      c = 2'h2;
    else if (b[6] || l > 7)
      c = 2'h1;
    else
      c = 2'h0;
    n = (c == 2'h2) ? 4 : (c == 2'h1) ? int'(b[5:4]) + 1 : int'(b[5]) + 1;
    for (int i = 0; i < n; i++)
      exp_q.push_back({1'b0, c, 5'(i), b});
    if (c == 2'h2) begin
      n = rom_len[b[5:4]];
      for (int i = 0; i < n; i++)
        exp_q.push_back({1'b1, c, 5'(i), b});
      rom_exp += (n + 3) / 4;
    end
    send(b);
    // trailing bytes must never be read as opcodes
    for (int i = 1; i < l; i++)
      send(8'hFF);
  endtask

  task automatic idle_fill();
    fill_valid <= 1'b0;
    fill_byte <= ~fill_byte;
  endtask

  task automatic drain();
    int k;
    k = 0;
    while (exp_q.size() != 0 && k < 2000) begin
      @(posedge ref_clk);
      k++;
    end
    tests_run++;
    if (exp_q.size() != 0)
      bad("ops missing");
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_short_long();
    ins(8'h01);
    ins(8'h21);
    ins(8'h07);
    ins(8'h08);
    ins(8'h0B);
    ins(8'h71);
    idle_fill();
    drain();
    $display("test short_long done");
  endtask

  task automatic t_vector();
    mode <= 2'h1;
    rom_seen = 0;
    rom_exp = 0;
    ins(8'h80);
    ins(8'h01);
    ins(8'h90);
    ins(8'hA0);
    ins(8'hB3);
    ins(8'h0C);
    ins(8'h0F);
    ins(8'h21);
    idle_fill();
    drain();
    tests_run++;
    if (rom_seen != rom_exp)
      bad("rom line count wrong");
    mode <= 2'h0;
    $display("test vector done");
  endtask

  task automatic t_stall();
    bit low_seen;
    low_seen = 0;
    pair_cnt = 0;
    mode <= 2'h2;
    fork
      begin
        for (int i = 0; i < 24; i++)
          ins(8'h01);
        idle_fill();
      end
      begin
        repeat (80) begin
          @(negedge ref_clk);
          if (fill_ready === 1'b0)
            low_seen = 1;
        end
        mode <= 2'h0;
      end
    join
    drain();
    tests_run++;
    if (!low_seen)
      bad("store never refused");
    tests_run++;
    if (pair_cnt == 0)
      bad("no short pair seen");
    $display("test stall done");
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_short_long();
    t_vector();
    t_stall();
    summarize();
  end
endmodule

// *** tb/vld_sched_model.sv ***
// scheduler stand-in that takes decoded lines and frees room slowly
`timescale 1ns/1ps

module vld_sched_model (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic [1:0] mode,
  input  wire logic       line_valid,
  input  wire logic [3:0] line_slot_vld,
  output logic            sched_ready
);
  // mode 0 prompt, 1 every other cycle, 2 stalled
  int   held;
  logic tick;

  // ---------------------------------------------------------------
  // op occupancy: 24 in flight at most, a few retired per clock
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    int nxt;
    nxt = held;
    if (sys_rst) begin
      held <= 0;
      tick <= 1'b0;
      sched_ready <= 1'b0;
    end else begin
      if (line_valid && sched_ready) begin
        nxt = nxt + $countones(line_slot_vld);
      end
      if (mode != 2'h2) begin
        nxt = (nxt > 3) ? nxt - 3 : 0;
      end
      held <= nxt;
      tick <= ~tick;
      // a line of up to four ops only fits with 20 or fewer held
      sched_ready <= (mode != 2'h2) && (nxt <= 20) &&
                     ((mode != 2'h1) || tick);
    end
  end
endmodule

// *** verilog/vld_decoder.sv ***
// predecode store, short/long/vector decode and microcode sequencing
`timescale 1ns/1ps
`include "vld_map.svh"

module vld_decoder (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        fill_valid,
  input  wire logic [7:0]  fill_byte,
  output logic             fill_ready,
  output logic             line_valid,
  input  wire logic        sched_ready,
  output logic [63:0]      line_ops,
  output logic [3:0]       line_slot_vld
);

  // -----------------------------------------------------------------
  // decode helpers
  // -----------------------------------------------------------------
  function automatic logic [3:0] len_of(input logic [7:0] b);
    len_of = (b[`VLD_F_LEN_HI:`VLD_F_LEN_LO] == 4'h0) ? 4'h1
           : b[`VLD_F_LEN_HI:`VLD_F_LEN_LO];
  endfunction

  // too long for the requested class escalates to the first class whose length limit it fits
  function automatic vld_pkg::vld_cls_e cls_of(input logic [7:0] b,
                                               input logic [3:0] l);
    if (b[`VLD_F_CLS_HI] || l > `VLD_LONG_MAX)
      cls_of = vld_pkg::VLD_CLS_VEC;
    else if (b[`VLD_F_CLS_LO] || l > `VLD_SHORT_MAX)
      cls_of = vld_pkg::VLD_CLS_LONG;
    else
      cls_of = vld_pkg::VLD_CLS_SHORT;
  endfunction

  function automatic logic [2:0] ops_of(input vld_pkg::vld_cls_e c,
                                        input logic [7:0] b);
    case (c)
      vld_pkg::VLD_CLS_SHORT: ops_of = {2'h0, 1'b1} + {2'h0, b[5]};
      vld_pkg::VLD_CLS_LONG:
        ops_of = {1'b0, b[`VLD_F_CNT_HI:`VLD_F_CNT_LO]} + 3'h1;
      default:                ops_of = `VLD_VEC_INIT;
    endcase
  endfunction

  // continuation length of each microcode entry point
  function automatic logic [4:0] rom_len(input logic [1:0] sel);
    case (sel)
      2'h0:    rom_len = 5'h04;
      2'h1:    rom_len = 5'h07;
      2'h2:    rom_len = 5'h0C;
      default: rom_len = 5'h14;
    endcase
  endfunction

  // -----------------------------------------------------------------
  // predecode store
  // -----------------------------------------------------------------
  logic [7:0] mem_byte [16];
  logic [3:0] mem_len  [16];
  logic [4:0] wr_r;
  logic [4:0] wr_nxt;
  logic [4:0] rd_r;
  logic [4:0] rd_nxt;
  logic [3:0] pd_rem_r;
  logic [3:0] pd_rem_nxt;
  logic       fill_ready_r;
  logic       fill_ready_nxt;
  logic       fill_we;
  logic [3:0] pd_len;
  logic [4:0] count;

  assign fill_we    = fill_valid && fill_ready_r;
  assign fill_ready = fill_ready_r;
  assign count      = wr_r - rd_r;

  always_comb begin
    wr_nxt     = wr_r;
    pd_rem_nxt = pd_rem_r;
    pd_len     = 4'h0;
    if (fill_we) begin
      wr_nxt = wr_r + 5'h01;
      // a byte with nothing pending opens a new instruction
      if (pd_rem_r == 4'h0) begin
        pd_len     = len_of(fill_byte);
        pd_rem_nxt = pd_len - 4'h1;
      end else begin
        pd_rem_nxt = pd_rem_r - 4'h1;
      end
    end
    fill_ready_nxt = (wr_nxt - rd_nxt) < `VLD_STORE_DEPTH;
  end

  always_ff @(posedge ref_clk) begin
    if (fill_we) begin
      mem_byte[wr_r[3:0]] <= fill_byte;
      mem_len[wr_r[3:0]]  <= pd_len;
    end
  end

  // -----------------------------------------------------------------
  // decode and ROM sequencing
  // -----------------------------------------------------------------
  vld_pkg::vld_state_e st_r;
  vld_pkg::vld_state_e st_nxt;
  logic [4:0]          rom_left_r;
  logic [4:0]          rom_left_nxt;
  logic [4:0]          rom_pos_r;
  logic [4:0]          rom_pos_nxt;
  logic [7:0]          vec_byte_r;
  logic [7:0]          vec_byte_nxt;
  logic [3:0]          idx0;
  logic [3:0]          idx1;
  logic [7:0]          b0;
  logic [7:0]          b1;
  logic [3:0]          l0;
  logic [3:0]          l1;
  vld_pkg::vld_cls_e   cls0;
  vld_pkg::vld_cls_e   cls1;
  logic [2:0]          n0;
  logic [2:0]          n1;
  logic                avail0;
  logic                avail1;
  logic                pair;
  logic                lv_c;
  vld_pkg::vld_op_t    op_c [4];
  logic [3:0]          sv_c;
  logic                buf_in_ready;
  logic                push;

  assign idx0   = rd_r[3:0];
  assign b0     = mem_byte[idx0];
  assign l0     = mem_len[idx0];
  assign idx1   = idx0 + l0;
  assign b1     = mem_byte[idx1];
  assign l1     = mem_len[idx1];
  assign cls0   = cls_of(b0, l0);
  assign cls1   = cls_of(b1, l1);
  assign n0     = ops_of(cls0, b0);
  assign n1     = ops_of(cls1, b1);
  // decode as soon as the whole instruction has been filled
  assign avail0 = (count != 5'h00) && (count >= {1'b0, l0});
  assign avail1 = (count > {1'b0, l0})
               && (count >= ({1'b0, l0} + {1'b0, l1}));
  assign push   = lv_c && buf_in_ready;

  always_comb begin
    st_nxt       = st_r;
    rd_nxt       = rd_r;
    rom_left_nxt = rom_left_r;
    rom_pos_nxt  = rom_pos_r;
    vec_byte_nxt = vec_byte_r;
    lv_c         = 1'b0;
    pair         = 1'b0;
    sv_c         = 4'h0;
    for (int k = 0; k < `VLD_LINE_OPS; k++) begin
      op_c[k] = '0;
    end
    case (st_r)
      vld_pkg::VLD_ST_DEC: begin
        lv_c = avail0;
        pair = (cls0 == vld_pkg::VLD_CLS_SHORT)
            && (cls1 == vld_pkg::VLD_CLS_SHORT) && avail1;
        for (int k = 0; k < `VLD_LINE_OPS; k++) begin
          if (k < int'(n0)) begin
            op_c[k] = {1'b0, cls0, 5'(k), b0};
            sv_c[k] = 1'b1;
          end else if (pair && k < int'(n0) + int'(n1)) begin
            op_c[k] = {1'b0, cls1, 5'(k - int'(n0)), b1};
            sv_c[k] = 1'b1;
          end
        end
        if (push) begin
          rd_nxt = rd_r + {1'b0, l0}
                 + (pair ? {1'b0, l1} : 5'h00);
          if (cls0 == vld_pkg::VLD_CLS_VEC) begin
            st_nxt       = vld_pkg::VLD_ST_ROM;
            rom_left_nxt = rom_len(b0[`VLD_F_CNT_HI:`VLD_F_CNT_LO]);
            rom_pos_nxt  = 5'h00;
            vec_byte_nxt = b0;
          end
        end
      end
      vld_pkg::VLD_ST_ROM: begin
        // rd_r holds still: nothing after the vector instruction starts
        lv_c = 1'b1;
        for (int k = 0; k < `VLD_LINE_OPS; k++) begin
          if (k < int'(rom_left_r)) begin
            op_c[k] = {1'b1, vld_pkg::VLD_CLS_VEC,
                       rom_pos_r + 5'(k), vec_byte_r};
            sv_c[k] = 1'b1;
          end
        end
        if (push) begin
          if (rom_left_r <= `VLD_ROM_RATE) begin
            st_nxt       = vld_pkg::VLD_ST_DEC;
            rom_left_nxt = 5'h00;
          end else begin
            rom_left_nxt = rom_left_r - `VLD_ROM_RATE;
            rom_pos_nxt  = rom_pos_r + `VLD_ROM_RATE;
          end
        end
      end
      default: st_nxt = vld_pkg::VLD_ST_DEC;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r         <= vld_pkg::VLD_ST_DEC;
      wr_r         <= 5'h00;
      rd_r         <= 5'h00;
      pd_rem_r     <= 4'h0;
      fill_ready_r <= 1'b0;
      rom_left_r   <= 5'h00;
      rom_pos_r    <= 5'h00;
      vec_byte_r   <= 8'h00;
    end else begin
      st_r         <= st_nxt;
      wr_r         <= wr_nxt;
      rd_r         <= rd_nxt;
      pd_rem_r     <= pd_rem_nxt;
      fill_ready_r <= fill_ready_nxt;
      rom_left_r   <= rom_left_nxt;
      rom_pos_r    <= rom_pos_nxt;
      vec_byte_r   <= vec_byte_nxt;
    end
  end

  // -----------------------------------------------------------------
  // scheduler line buffer
  // -----------------------------------------------------------------
  // a full buffer holds back consumption, so a stall loses no line
  vld_line_buf #(
    .WIDTH (68)
  ) u_line_buf (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_valid  (lv_c),
    .in_ready  (buf_in_ready),
    .in_data   ({sv_c, op_c[3], op_c[2], op_c[1], op_c[0]}),
    .out_valid (line_valid),
    .out_ready (sched_ready),
    .out_data  ({line_slot_vld, line_ops})
  );

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_vec_start;
    push && st_r == vld_pkg::VLD_ST_DEC && cls0 == vld_pkg::VLD_CLS_VEC;
  endsequence
  // a short sequence may leave the rom state after one line
  sequence s_rom_entered;
    st_r == vld_pkg::VLD_ST_ROM && rom_pos_r == 5'h00
      && rom_left_r != 5'h00 && lv_c;
  endsequence

  short_len_a: assert property (
    push && st_r == vld_pkg::VLD_ST_DEC
      && cls0 == vld_pkg::VLD_CLS_SHORT
    |-> l0 <= `VLD_SHORT_MAX && (n0 == 3'h1 || n0 == 3'h2))
    else $error("short decode out of limits");
  pair_ops_a: assert property (
    push && pair |-> ({1'b0, n0} + {1'b0, n1}) <= 4'h4
      ##1 rd_r == $past(rd_r) + {1'b0, $past(l0)} + {1'b0, $past(l1)})
    else $error("short pair wrong");
  long_len_a: assert property (
    push && st_r == vld_pkg::VLD_ST_DEC
      && cls0 == vld_pkg::VLD_CLS_LONG
    |-> l0 <= `VLD_LONG_MAX && !pair && sv_c[0])
    else $error("long decode out of limits");
  vec_entry_a: assert property (
    s_vec_start |-> sv_c == 4'hF ##1 s_rom_entered)
    else $error("vector start wrong");
  rom_rate_a: assert property (
    push && st_r == vld_pkg::VLD_ST_ROM && rom_left_r > 5'h04
    |-> sv_c == 4'hF ##1 rom_left_r == $past(rom_left_r) - 5'h04)
    else $error("rom rate wrong");
  rom_hold_a: assert property (
    st_r == vld_pkg::VLD_ST_ROM |=> rd_r == $past(rd_r))
    else $error("decode during rom sequence");
  stall_hold_a: assert property (
    !buf_in_ready |=> rd_r == $past(rd_r)
      && rom_left_r == $past(rom_left_r))
    else $error("progress while stalled");
  slot_mask_a: assert property (
    push |-> sv_c == 4'h1 || sv_c == 4'h3 || sv_c == 4'h7
      || sv_c == 4'hF)
    else $error("slot mask not contiguous");
  dec_no_rom_a: assert property (
    push && st_r == vld_pkg::VLD_ST_DEC
    |-> !op_c[0][15] && !op_c[3][15])
    else $error("decoder op tagged as rom");
  insn_len_a: assert property (
    avail0 && st_r == vld_pkg::VLD_ST_DEC
    |-> l0 != 4'h0 && l0 <= `VLD_INSN_MAX)
    else $error("decode not on a boundary");

endmodule

// *** verilog/vld_line_buf.sv ***
// two-entry line buffer, outputs held in flip-flops
`timescale 1ns/1ps

module vld_line_buf #(
  parameter int WIDTH = 68
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  logic             main_v_r;
  logic             main_v_nxt;
  logic [WIDTH-1:0] main_r;
  logic [WIDTH-1:0] main_nxt;
  logic             skid_v_r;
  logic             skid_v_nxt;
  logic [WIDTH-1:0] skid_r;
  logic [WIDTH-1:0] skid_nxt;

  // the skid entry catches the word taken while the receiver stalls
  assign in_ready  = !skid_v_r;
  assign out_valid = main_v_r;
  assign out_data  = main_r;

  always_comb begin
    main_v_nxt = main_v_r;
    main_nxt   = main_r;
    skid_v_nxt = skid_v_r;
    skid_nxt   = skid_r;
    if (!main_v_r || out_ready) begin
      if (skid_v_r) begin
        main_nxt   = skid_r;
        main_v_nxt = 1'b1;
        skid_v_nxt = 1'b0;
      end else begin
        // only a real word is loaded, so idle outputs stay quiet
        main_v_nxt = in_valid;
        if (in_valid) begin
          main_nxt = in_data;
        end
      end
    end else if (in_valid && !skid_v_r) begin
      skid_nxt   = in_data;
      skid_v_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      main_v_r <= 1'b0;
      skid_v_r <= 1'b0;
      main_r   <= '0;
      skid_r   <= '0;
    end else begin
      main_v_r <= main_v_nxt;
      skid_v_r <= skid_v_nxt;
      main_r   <= main_nxt;
      skid_r   <= skid_nxt;
    end
  end

endmodule

// *** verilog/vld_map.svh ***
// constants for the variable-length operation decoder
`ifndef VLD_MAP_SVH
`define VLD_MAP_SVH

// -----------------------------------------------------------------
// class length limits (bytes)
// -----------------------------------------------------------------
`define VLD_SHORT_MAX   4'h7
`define VLD_LONG_MAX    4'hB
`define VLD_INSN_MAX    4'hF

// -----------------------------------------------------------------
// line and sequence sizes
// -----------------------------------------------------------------
`define VLD_LINE_OPS    4
`define VLD_VEC_INIT    3'h4
`define VLD_ROM_RATE    5'h04
`define VLD_STORE_DEPTH 5'h10

// -----------------------------------------------------------------
// opcode byte fields
// -----------------------------------------------------------------
`define VLD_F_CLS_HI    7
`define VLD_F_CLS_LO    6
`define VLD_F_CNT_HI    5
`define VLD_F_CNT_LO    4
`define VLD_F_LEN_HI    3
`define VLD_F_LEN_LO    0

`endif

// *** verilog/vld_pkg.sv ***
// types shared by the variable-length operation decoder
package vld_pkg;

  typedef enum logic [1:0] {
    VLD_ST_DEC = 2'b01,
    VLD_ST_ROM = 2'b10
  } vld_state_e;

  typedef enum logic [1:0] {
    VLD_CLS_SHORT = 2'h0,
    VLD_CLS_LONG  = 2'h1,
    VLD_CLS_VEC   = 2'h2
  } vld_cls_e;

  // {from_rom, class, sequence index, source opcode byte}
  typedef logic [15:0] vld_op_t;

endpackage
